// *** hw/cre_pkg.sv ***
// Package of constants, offsets and carrier types for the control register extension block
package cre_pkg;
   // Register offsets (word-aligned byte addresses)
   localparam logic [7:0] ADDR_CTRL_LO = 8'h00; // Control bits 0..23
   localparam logic [7:0] ADDR_CTRL_HI = 8'h04; // Control bits 24..47
   localparam logic [7:0] ADDR_SESSION = 8'h08; // Write session control
   localparam logic [7:0] ADDR_STATUS = 8'h0C; // Block state, read only
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h10; // Sticky events, read only
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h14; // Write one to clear
   localparam logic [7:0] ADDR_IRQ_EN = 8'h18; // Interrupt enables
   // Control register layout
   localparam int CTRL_W = 48;
   localparam int BASE_W = 24;
   localparam int BIT_FREEZE = 17;
   localparam int BIT_EXT_EN = 21;
   localparam int HDR_LSB = 24;
   localparam int HDR_MSB = 39;
   localparam int LEN_LSB = 40;
   localparam int LEN_MSB = 47;
   // Reset values; upper part holds header 9B58 and frame length 08
   localparam logic [23:0] CTRL_LO_RST = 24'h000000;
   localparam logic [23:0] CTRL_HI_RST = 24'h089B58;
   // Session register bits
   localparam int SES_OPEN = 0;
   localparam int SES_CLOSE = 1;
   // Status register bits
   localparam int ST_INTEG = 0;
   localparam int ST_TIMEOUT_OUTPUT_LINE = 1;
   localparam int ST_PGOOD = 2;
   localparam int ST_EXT = 3;
   localparam int ST_DRV = 4;
   localparam int ST_SES = 5;
   // Interrupt bits
   localparam int IRQ_W = 4;
   localparam int EV_INTEG = 0;
   localparam int EV_THERM = 1;
   localparam int EV_TXTO = 2;
   localparam int EV_PGLOSS = 3;
   // Timing
   localparam int CLK_HZ = 40_000_000;
   localparam int TIMEOUT_OUTPUT_LINE_HOLD_MS = 125;
   localparam int TIMEOUT_OUTPUT_LINE_HOLD_CYC = (CLK_HZ / 1000) * TIMEOUT_OUTPUT_LINE_HOLD_MS;
   // Startup blanking of power good, in cycles
   localparam int PG_START_CYC = 16;
   // Register bus carriers
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } cre_bus_req_t;
   // Feature gates derived from the control register
   typedef struct packed {
      logic ext_en;
      logic hdr_match_en;
      logic bit_count_en;
      logic freeze_en;
   } cre_feat_t;
   // Power good state machine
   typedef enum logic [1:0] {
      PG_START = 2'b00,
      PG_WAIT = 2'b01,
      PG_GOOD = 2'b11
   } cre_pg_state_t;
endpackage

// *** hw/cre_timeout_output_line_hold.sv ***
// Stretcher that holds the time-out indication for a minimum time
module cre_timeout_output_line_hold #(
   parameter int HOLD_CYC = cre_pkg::TIMEOUT_OUTPUT_LINE_HOLD_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Event in and stretched level out
   input wire logic trig,
   output logic hold
);
   localparam int CW = $clog2(HOLD_CYC + 1);

   // Elaboration refuses a zero-length hold
   if (HOLD_CYC < 1) begin : g_bad_hold
      $error("HOLD_CYC must be at least 1");
   end

   logic [CW-1:0] cnt_r, cnt_nxt;
   logic hold_r, hold_nxt;

   // Restart the count on every trigger; hold while counting
   always_comb begin
      cnt_nxt = cnt_r;
      hold_nxt = hold_r;
      if (trig) begin
         cnt_nxt = CW'(HOLD_CYC - 1);
         hold_nxt = 1'b1;
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - 1'b1;
      end else begin
         hold_nxt = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
         hold_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         hold_r <= hold_nxt;
      end
   end

   assign hold = hold_r;
endmodule

// *** hw/cre_top.sv ***
// Control register gating, integrity flag, thermal, time-out and power good outputs
// Function
// - Extension enabled makes all 48 bits writable; otherwise only low 24.
// - Header match, bit count and level freeze active only with extension.
// - Control bit 21 is the extension enable.
// - Integrity flag set on incomplete write session or stored content corruption.
// - Integrity flag stays set until a new write session is performed.
// - Thermal shutdown switches the line interface driver off.
// - Time-out line follows the over-temperature condition, not latched.
// - Power good goes high once both regulators report above threshold.
// - Power good low at startup and when either supply falls below.
// - Bit 17 enables level freeze, honoured only with extension active.
// - Header in bits 24..39 MSB first, frame length in bits 40..47.
// - Transmission time-out holds the time-out line high at least 125 ms.
module cre_top #(
   parameter int TIMEOUT_OUTPUT_LINE_HOLD_CYC = cre_pkg::TIMEOUT_OUTPUT_LINE_HOLD_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Register bus
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Analog monitor inputs, asynchronous
   input wire logic therm_over,
   input wire logic vdc_above_pg,
   input wire logic dvdd_above_pg,
   input wire logic vdc_below_hys,
   input wire logic dvdd_below_hys,
   // Core events, same clock
   input wire logic tx_timeout,
   input wire logic ctrl_corrupt,
   input wire logic tx_drive_req,
   // Outputs
   output logic [47:0] ctrl_word,
   output logic [15:0] frame_header,
   output logic [7:0] frame_length,
   output logic hdr_match_en,
   output logic bit_count_en,
   output logic freeze_en,
   output logic line_interface_driver,
   output logic timeout_output_line,
   output logic register_integrity_flag,
   output logic power_good,
   output logic irq
);
   // Refuse a hold of zero cycles and a blanking that outgrows its counter
   if (TIMEOUT_OUTPUT_LINE_HOLD_CYC < 1) begin : g_bad_hold
      $error("TIMEOUT_OUTPUT_LINE_HOLD_CYC must be at least 1");
   end
   if (cre_pkg::PG_START_CYC < 1 || cre_pkg::PG_START_CYC > 32) begin : g_bad_start
      $error("PG_START_CYC must lie between 1 and 32");
   end

   // Two-flop synchronisers for asynchronous monitor inputs
   // Reset to zero: supplies read low and the die cool until sampled
   logic [4:0] async_in, sync1_r, sync2_r;
   assign async_in = {therm_over, vdc_above_pg, dvdd_above_pg, vdc_below_hys, dvdd_below_hys};
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync1_r <= 5'h00;
         sync2_r <= 5'h00;
      end else begin
         sync1_r <= async_in;
         sync2_r <= sync1_r;
      end
   end
   logic therm_s, vdc_up_s, dvdd_up_s, vdc_dn_s, dvdd_dn_s;
   assign {therm_s, vdc_up_s, dvdd_up_s, vdc_dn_s, dvdd_dn_s} = sync2_r;

   // Bus request carrier
   cre_pkg::cre_bus_req_t req;
   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // Address compare shared by the write decoders; the read mux uses a case
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // Transmission time-out stretcher
   // Each pulse restarts the stretch, so a burst keeps the line high
   logic txto_hold;
   cre_timeout_output_line_hold #(
      .HOLD_CYC(TIMEOUT_OUTPUT_LINE_HOLD_CYC)
   ) u_hold (
      .ref_clk(ref_clk),
      .rst(rst),
      .trig(tx_timeout),
      .hold(txto_hold)
   );

   // Control register and write session state
   logic [47:0] ctrl_r, ctrl_nxt;
   logic ses_r, ses_nxt;
   logic integ_r, integ_nxt;
   logic wr_lo, wr_hi, wr_ses, ses_open, ses_close, ext_on;
   assign ext_on = ctrl_r[cre_pkg::BIT_EXT_EN];
   assign wr_lo = req.wr && hit(req.addr, cre_pkg::ADDR_CTRL_LO);
   assign wr_hi = req.wr && hit(req.addr, cre_pkg::ADDR_CTRL_HI);
   assign wr_ses = req.wr && hit(req.addr, cre_pkg::ADDR_SESSION);
   assign ses_open = wr_ses && req.wdata[cre_pkg::SES_OPEN];
   assign ses_close = wr_ses && req.wdata[cre_pkg::SES_CLOSE];

   // Session: open, write words, close. The close checks which halves
   // arrived: both when extension is on, else only the low half; a
   // missing half sets the integrity flag. Words written outside a
   // session are dropped, so a stray write cannot half-update the word
   // that the modem core is running on.
   logic got_lo_r, got_lo_nxt, got_hi_r, got_hi_nxt;
   always_comb begin
      ctrl_nxt = ctrl_r;
      ses_nxt = ses_r;
      got_lo_nxt = got_lo_r;
      got_hi_nxt = got_hi_r;
      integ_nxt = integ_r;
      if (ses_open) begin
         ses_nxt = 1'b1;
         got_lo_nxt = 1'b0;
         got_hi_nxt = 1'b0;
         integ_nxt = 1'b0;
      end
      if (wr_lo && (ses_r || ses_open)) begin
         ctrl_nxt[cre_pkg::BASE_W-1:0] = req.wdata[23:0];
         got_lo_nxt = 1'b1;
      end
      if (wr_hi && (ses_r || ses_open) && ext_on) begin
         ctrl_nxt[cre_pkg::CTRL_W-1:cre_pkg::BASE_W] = req.wdata[23:0];
         got_hi_nxt = 1'b1;
      end
      // Extension dropped: upper part goes back to its defaults
      if (!ctrl_nxt[cre_pkg::BIT_EXT_EN]) begin
         ctrl_nxt[cre_pkg::CTRL_W-1:cre_pkg::BASE_W] = cre_pkg::CTRL_HI_RST;
      end
      if (ses_close && ses_r) begin
         ses_nxt = 1'b0;
         if (!got_lo_r || (ext_on && !got_hi_r)) begin
            integ_nxt = 1'b1;
         end
      end
      // Corruption sets the flag; set wins over a session open
      if (ctrl_corrupt) begin
         integ_nxt = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_r <= {cre_pkg::CTRL_HI_RST, cre_pkg::CTRL_LO_RST};
         ses_r <= 1'b0;
         got_lo_r <= 1'b0;
         got_hi_r <= 1'b0;
         integ_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         ses_r <= ses_nxt;
         got_lo_r <= got_lo_nxt;
         got_hi_r <= got_hi_nxt;
         integ_r <= integ_nxt;
      end
   end

   // Feature gating from the stored word
   // Gates use the next value so they line up with the registered word
   cre_pkg::cre_feat_t feat;
   always_comb begin
      feat.ext_en = ctrl_nxt[cre_pkg::BIT_EXT_EN];
      feat.hdr_match_en = feat.ext_en;
      feat.bit_count_en = feat.ext_en;
      feat.freeze_en = feat.ext_en && ctrl_nxt[cre_pkg::BIT_FREEZE];
   end

   // Power good state machine, low during startup blanking
   // Entry to GOOD also needs both low flags clear, so a supply that
   // sits between the two thresholds cannot make the output bounce
   cre_pkg::cre_pg_state_t pg_r, pg_nxt;
   logic [4:0] pg_cnt_r, pg_cnt_nxt;
   always_comb begin
      pg_nxt = pg_r;
      pg_cnt_nxt = pg_cnt_r;
      case (pg_r)
         cre_pkg::PG_START: begin
            if (pg_cnt_r == 5'(cre_pkg::PG_START_CYC - 1)) begin
               pg_nxt = cre_pkg::PG_WAIT;
            end else begin
               pg_cnt_nxt = pg_cnt_r + 5'h01;
            end
         end
         cre_pkg::PG_WAIT: begin
            if (vdc_up_s && dvdd_up_s && !vdc_dn_s && !dvdd_dn_s) begin
               pg_nxt = cre_pkg::PG_GOOD;
            end
         end
         cre_pkg::PG_GOOD: begin
            if (vdc_dn_s || dvdd_dn_s) begin
               pg_nxt = cre_pkg::PG_WAIT;
            end
         end
         default: pg_nxt = cre_pkg::PG_START;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pg_r <= cre_pkg::PG_START;
         pg_cnt_r <= 5'h00;
      end else begin
         pg_r <= pg_nxt;
         pg_cnt_r <= pg_cnt_nxt;
      end
   end

   // Interrupt status, enable; set wins over clear
   logic [3:0] ev;
   logic [3:0] ist_r, ist_nxt, ien_r, ien_nxt;
   logic pg_was_r;
   logic ev_integ, ev_therm, ev_txto, ev_pgloss;
   // Rising edge only, so a flag that stays up sets its bit once
   assign ev_integ = integ_nxt && !integ_r;
   // Thermal is a level: its bit sets again after a clear while hot
   assign ev_therm = therm_s;
   // Only the pulse that starts a stretch counts as a new time-out
   assign ev_txto = tx_timeout && !txto_hold;
   // Power good falling, seen in the cycle the output is about to drop
   assign ev_pgloss = pg_was_r && (pg_nxt != cre_pkg::PG_GOOD);
   always_comb begin
      ev = 4'h0;
      ev[cre_pkg::EV_INTEG] = ev_integ;
      ev[cre_pkg::EV_THERM] = ev_therm;
      ev[cre_pkg::EV_TXTO] = ev_txto;
      ev[cre_pkg::EV_PGLOSS] = ev_pgloss;
   end
   always_comb begin
      ist_nxt = ist_r;
      ien_nxt = ien_r;
      if (req.wr && hit(req.addr, cre_pkg::ADDR_IRQ_CLR)) begin
         ist_nxt = ist_nxt & ~req.wdata[3:0];
      end
      // Clear first, then set, so an event in the clear cycle survives
      ist_nxt = ist_nxt | ev;
      if (req.wr && hit(req.addr, cre_pkg::ADDR_IRQ_EN)) begin
         ien_nxt = req.wdata[3:0];
      end
   end

   // Read mux; unmapped addresses read zero
   // The strobe gates the mux, so the data word is zero except in the cycle after the strobe
   logic [31:0] rdata_nxt;
   logic [5:0] status;
   assign status = {ses_r, line_interface_driver, ext_on, power_good, timeout_output_line, integ_r};
   always_comb begin
      rdata_nxt = 32'h00000000;
      if (req.rd) begin
         case (req.addr)
            cre_pkg::ADDR_CTRL_LO: rdata_nxt = {8'h00, ctrl_r[23:0]};
            cre_pkg::ADDR_CTRL_HI: rdata_nxt = {8'h00, ctrl_r[47:24]};
            cre_pkg::ADDR_SESSION: rdata_nxt = {31'h00000000, ses_r};
            cre_pkg::ADDR_STATUS: rdata_nxt = {26'h0000000, status};
            cre_pkg::ADDR_IRQ_STAT: rdata_nxt = {28'h0000000, ist_r};
            cre_pkg::ADDR_IRQ_EN: rdata_nxt = {28'h0000000, ien_r};
            default: rdata_nxt = 32'h00000000;
         endcase
      end
   end

   // Registered outputs
   // Next-state values are registered, so a write shows at the edge that takes it
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ist_r <= 4'h0;
         ien_r <= 4'h0;
         pg_was_r <= 1'b0;
         reg_rdata <= 32'h00000000;
         ctrl_word <= {cre_pkg::CTRL_HI_RST, cre_pkg::CTRL_LO_RST};
         frame_header <= cre_pkg::CTRL_HI_RST[15:0];
         frame_length <= cre_pkg::CTRL_HI_RST[23:16];
         hdr_match_en <= 1'b0;
         bit_count_en <= 1'b0;
         freeze_en <= 1'b0;
         line_interface_driver <= 1'b0;
         timeout_output_line <= 1'b0;
         register_integrity_flag <= 1'b0;
         power_good <= 1'b0;
         irq <= 1'b0;
      end else begin
         ist_r <= ist_nxt;
         ien_r <= ien_nxt;
         pg_was_r <= (pg_nxt == cre_pkg::PG_GOOD);
         reg_rdata <= rdata_nxt;
         ctrl_word <= ctrl_nxt;
         frame_header <= ctrl_nxt[cre_pkg::HDR_MSB:cre_pkg::HDR_LSB];
         frame_length <= ctrl_nxt[cre_pkg::LEN_MSB:cre_pkg::LEN_LSB];
         hdr_match_en <= feat.hdr_match_en;
         bit_count_en <= feat.bit_count_en;
         freeze_en <= feat.freeze_en;
         // Driver cut from the synchronised thermal level, never the raw pin
         line_interface_driver <= tx_drive_req && !therm_s;
         timeout_output_line <= therm_s || txto_hold || tx_timeout;
         register_integrity_flag <= integ_nxt;
         power_good <= (pg_nxt == cre_pkg::PG_GOOD);
         irq <= |(ist_nxt & ien_nxt);
      end
   end
endmodule

// *** verification/cre_top_asserts.sv ***
// Concurrent checks on the ports of the control register extension block
module cre_top_asserts (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Bus and monitor inputs
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic therm_over,
   input wire logic vdc_above_pg,
   input wire logic dvdd_above_pg,
   input wire logic vdc_below_hys,
   input wire logic dvdd_below_hys,
   input wire logic tx_timeout,
   input wire logic ctrl_corrupt,
   // Outputs watched
   input wire logic [47:0] ctrl_word,
   input wire logic [15:0] frame_header,
   input wire logic [7:0] frame_length,
   input wire logic hdr_match_en,
   input wire logic freeze_en,
   input wire logic line_interface_driver,
   input wire logic timeout_output_line,
   input wire logic register_integrity_flag,
   input wire logic power_good
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic [4:0] up_cnt_r;
   logic [4:0] up_cnt_nxt;
   // Saturating age since reset, bounds the startup blanking window
   always_comb begin
      up_cnt_nxt = (up_cnt_r == 5'h1F) ? up_cnt_r : up_cnt_r + 5'h01;
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         up_cnt_r <= 5'h00;
      end else begin
         up_cnt_r <= up_cnt_nxt;
      end
   end
   // Hot long enough to pass the synchroniser
   sequence s_hot;
      therm_over [*4];
   endsequence
   sequence s_supply_ok;
      (vdc_above_pg && dvdd_above_pg && !vdc_below_hys && !dvdd_below_hys) [*6];
   endsequence
   a_gate_hdr: assert property (hdr_match_en == ctrl_word[21])
      else $error("header match gate differs from extension bit");
   a_gate_freeze: assert property (freeze_en == (ctrl_word[21] && ctrl_word[17]))
      else $error("freeze gate wrong");
   a_field_map: assert property (frame_header == ctrl_word[39:24] && frame_length == ctrl_word[47:40])
      else $error("header or length field misplaced");
   a_ext_default: assert property (!ctrl_word[21] |-> ctrl_word[47:24] == 24'h089B58)
      else $error("upper bits changed with extension off");
   a_hot_drv_off: assert property (s_hot |-> !line_interface_driver)
      else $error("driver on while hot");
   a_hot_timeout_output_line: assert property (s_hot |-> timeout_output_line)
      else $error("time-out line low while hot");
   a_txto_hold: assert property (tx_timeout |=> timeout_output_line [*8])
      else $error("time-out not held");
   a_integ_set: assert property (ctrl_corrupt |-> ##[1:2] register_integrity_flag)
      else $error("integrity flag not set on corruption");
   a_integ_hold: assert property (register_integrity_flag && !(reg_wr && reg_addr == cre_pkg::ADDR_SESSION)
      |=> register_integrity_flag)
      else $error("integrity flag dropped without session");
   a_pg_start: assert property (up_cnt_r < 5'h10 |-> !power_good)
      else $error("power good during startup");
   a_pg_high: assert property (s_supply_ok |-> up_cnt_r != 5'h1F || power_good)
      else $error("power good missing");
   a_pg_low: assert property ((vdc_below_hys || dvdd_below_hys) [*5] |-> !power_good)
      else $error("power good high with supply low");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
      else $error("read data outside read cycle");
endmodule

// *** verification/cre_host_model.sv ***
// Host model driving the register bus of the control register block
module cre_host_model (
   // Clock
   input wire logic ref_clk,
   // Register bus
   output logic [7:0] reg_addr,
   output logic [31:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [31:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   // Idle bus at time zero
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 32'h00000000;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
   end
   // One-cycle write; next call waits a fresh edge so strobes never collide
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge ref_clk);
      reg_wr <= 1'h0;
   endtask
   // Read data only stands in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge ref_clk);
      reg_rd <= 1'h0;
      #1;
      d = reg_rdata;
   endtask
   // Open, low then high half, close; full=0 leaves the session incomplete
   task automatic session(input logic [23:0] lo, input logic [23:0] hi, input bit full);
      wr(cre_pkg::ADDR_SESSION, 32'h00000001);
      if (full) begin
         wr(cre_pkg::ADDR_CTRL_LO, {8'h00, lo});
         wr(cre_pkg::ADDR_CTRL_HI, {8'h00, hi});
      end
      wr(cre_pkg::ADDR_SESSION, 32'h00000002);
   endtask
endmodule

// *** verification/cre_top_tb_top.sv ***
// Self-checking bench for the control register extension block
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin fail_count++; \
   $display("mismatch %s exp %h got %h", nm, exp, got); end end
module cre_top_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk = 1'h0;
   logic rst = 1'h1;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic reg_wr, reg_rd, irq, hdr_match_en, bit_count_en, freeze_en, line_interface_driver;
   logic timeout_output_line, register_integrity_flag, power_good;
   logic therm_over = 1'h0, vdc_above_pg = 1'h0, dvdd_above_pg = 1'h0, vdc_below_hys = 1'h0;
   logic dvdd_below_hys = 1'h0, tx_timeout = 1'h0, ctrl_corrupt = 1'h0, tx_drive_req = 1'h0;
   logic [47:0] ctrl_word;
   logic [15:0] frame_header;
   logic [7:0] frame_length;
   int compares = 0, fail_count = 0, cyc = 0;
   always #12.5 ref_clk = ~ref_clk;
   cre_host_model hostm (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   cre_top #(.TIMEOUT_OUTPUT_LINE_HOLD_CYC(20)) uut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .therm_over(therm_over),
      .vdc_above_pg(vdc_above_pg), .dvdd_above_pg(dvdd_above_pg), .vdc_below_hys(vdc_below_hys),
      .dvdd_below_hys(dvdd_below_hys), .tx_timeout(tx_timeout), .ctrl_corrupt(ctrl_corrupt),
      .tx_drive_req(tx_drive_req), .ctrl_word(ctrl_word), .frame_header(frame_header),
      .frame_length(frame_length), .hdr_match_en(hdr_match_en), .bit_count_en(bit_count_en),
      .freeze_en(freeze_en), .line_interface_driver(line_interface_driver),
      .timeout_output_line(timeout_output_line), .register_integrity_flag(register_integrity_flag),
      .power_good(power_good), .irq(irq));
   // Upper half expected: written value only with extension on
   function automatic logic [23:0] exp_hi(input logic ext, input logic [23:0] hi);
      return ext ? hi : cre_pkg::CTRL_HI_RST;
   endfunction
   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Hang guard, well above the few hundred cycles the run needs
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         summarize();
      end
   end
   initial begin
      logic [31:0] d;
      logic [23:0] lo, hi, hx;
      void'($urandom(95483));
      repeat (12) @(posedge ref_clk);
      rst <= 1'h0;
      settle(1);
      `CHK("ctrl_word", 48'h089B58000000, ctrl_word)
      `CHK("pgood", 1'h0, power_good)
      vdc_above_pg <= 1'h1;
      dvdd_above_pg <= 1'h1;
      settle(30);
      `CHK("pgood", 1'h1, power_good)
      dvdd_below_hys <= 1'h1;
      settle(6);
      `CHK("pgood", 1'h0, power_good)
      dvdd_below_hys <= 1'h0;
      // Alternate extension off and on; last pass writes all ones to the low half, upper half random
      for (int i = 0; i < 6; i++) begin
         lo = (i == 5) ? 24'hFFFFFF : 24'($urandom());
         hi = 24'($urandom());
         lo[21] = i[0];
         hostm.session(lo, hi, 1'h1);
         settle(2);
         hx = exp_hi(lo[21], hi);
         `CHK("ctrl_lo", lo, ctrl_word[23:0])
         `CHK("ctrl_hi", hx, ctrl_word[47:24])
         `CHK("hdr_en", lo[21], hdr_match_en)
         `CHK("cnt_en", lo[21], bit_count_en)
         `CHK("freeze", lo[21] & lo[17], freeze_en)
         `CHK("header", hx[15:0], frame_header)
         `CHK("length", hx[23:16], frame_length)
         `CHK("integ", 1'h0, register_integrity_flag)
         hostm.rd(cre_pkg::ADDR_CTRL_LO, d);
         `CHK("rd_lo", lo, d[23:0])
      end
      hostm.session(lo, hi, 1'h0);
      settle(2);
      `CHK("integ", 1'h1, register_integrity_flag)
      settle(20);
      `CHK("integ", 1'h1, register_integrity_flag)
      hostm.session(lo, hi, 1'h1);
      settle(2);
      `CHK("integ", 1'h0, register_integrity_flag)
      ctrl_corrupt <= 1'h1;
      settle(1);
      ctrl_corrupt <= 1'h0;
      settle(2);
      `CHK("integ", 1'h1, register_integrity_flag)
      // Thermal event while masked, then unmask, cool down and clear
      hostm.wr(cre_pkg::ADDR_IRQ_CLR, 32'h0000000F);
      hostm.wr(cre_pkg::ADDR_IRQ_EN, 32'h00000000);
      tx_drive_req <= 1'h1;
      therm_over <= 1'h1;
      settle(5);
      `CHK("driver", 1'h0, line_interface_driver)
      `CHK("timeout_output_line", 1'h1, timeout_output_line)
      `CHK("irq", 1'h0, irq)
      hostm.rd(cre_pkg::ADDR_IRQ_STAT, d);
      `CHK("stat_therm", 1'h1, d[cre_pkg::EV_THERM])
      hostm.wr(cre_pkg::ADDR_IRQ_EN, 32'h00000002);
      settle(1);
      `CHK("irq", 1'h1, irq)
      therm_over <= 1'h0;
      settle(5);
      `CHK("timeout_output_line", 1'h0, timeout_output_line)
      `CHK("driver", 1'h1, line_interface_driver)
      hostm.wr(cre_pkg::ADDR_IRQ_CLR, 32'h00000002);
      settle(1);
      `CHK("irq", 1'h0, irq)
      tx_timeout <= 1'h1;
      settle(1);
      tx_timeout <= 1'h0;
      settle(15);
      `CHK("timeout_output_line_hold", 1'h1, timeout_output_line)
      settle(15);
      `CHK("timeout_output_line_end", 1'h0, timeout_output_line)
      hostm.rd(cre_pkg::ADDR_STATUS, d);
      `CHK("status", 6'h1D, d[5:0])
      hostm.rd(8'h1C, d);
      `CHK("unmapped", 32'h00000000, d)
      summarize();
   end
endmodule
bind cre_top cre_top_asserts u_chk (.*);
